// ===== core/timer_module_regs.vh
`ifndef TIMER_MODULE_REGS_VH
`define TIMER_MODULE_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define TM_ADDR_W      4
`define TM_CTRL0       4'h0
`define TM_CTRL1       4'h1
`define TM_CNT_LO      4'h2
`define TM_CNT_HI      4'h3
`define TM_CMPA_LO     4'h4
`define TM_CMPA_HI     4'h5
`define TM_CMPP_LO     4'h6
`define TM_CMPP_HI     4'h7
`define TM_STATUS      4'h8
`define TM_AUX         4'h9

// ****************************************
// control_reg0 fields
// ****************************************
`define C0_PAUSE       7
`define C0_CKSEL_HI    6
`define C0_CKSEL_LO    4
`define C0_ON          3

// ****************************************
// control_reg1 fields
// ****************************************
`define C1_MODE_HI     7
`define C1_MODE_LO     6
`define C1_IO_HI       5
`define C1_IO_LO       4
`define C1_OC          3
`define C1_POL         2
`define C1_DPX         1
`define C1_CCLR        0

// ****************************************
// status and aux fields
// ****************************************
`define ST_FLAG_A      0
`define ST_FLAG_P      1
`define AUX_CAP_PER    0

// ****************************************
// encodings
// ****************************************
`define CK_SYS_DIV4    3'h0
`define CK_SYS         3'h1
`define CK_HI_DIV16    3'h2
`define CK_HI_DIV64    3'h3
`define CK_SUB_A       3'h4
`define CK_SUB_B       3'h5
`define CK_EXT_RISE    3'h6
`define CK_EXT_FALL    3'h7
`define MODE_CMP_OUT   2'h0
`define MODE_CAPTURE   2'h1
`define MODE_PWM       2'h2
`define MODE_COUNTER   2'h3
`define IO_RISE        2'h0
`define IO_FALL        2'h1
`define IO_BOTH        2'h2
`define OUT_KEEP       2'h0
`define OUT_LOW        2'h1
`define OUT_HIGH       2'h2
`define OUT_TOGGLE     2'h3
`define PWM_SINGLE     2'h3

// ****************************************
// reset values and sizes
// ****************************************
`define CNT_W          10
`define CTRL_RST       8'h00
`define CMP_RST        10'h000

`endif

// ===== core/timer_module.v
`include "timer_module_regs.vh"

// Behaviour
// - counter equal to comparator is a match
// - match raises interrupt, may clear, drive pin
// - three-bit clock select in control_reg0
// - sources: system ratios, high, sub, pin
// - external pin edges advance the counter
// - separate interrupts for comparators A and P
// - external clock edge rising or falling
// - external pin triggers single pulse
// - capture edge rising, falling or both
// - periodic pin alternative capture and trigger
// - compare output sets, clears or toggles pin
// - PWM leaves on the compare output pin
// - edge-aligned PWM, duty or period comparator
// - counter, capture, compare, pulse, PWM modes
// - enable rise zeroes, fall holds count
// - pause freezes and resumes the count
// - clock select encoding per table
// - low bytes move through shared buffer
module timer_module (
	input  wire                  mclk_i,
	input  wire                  rst_i,
	input  wire [`TM_ADDR_W-1:0] addr_i,
	input  wire [7:0]            wdata_i,
	input  wire                  wr_i,
	input  wire                  rd_i,
	output reg  [7:0]            rdata_o,
	input  wire                  sub_clock_i,
	input  wire                  ext_clock_pin_i,
	input  wire                  capture_input_pin_i,
	input  wire                  periodic_clock_capture_pin_i,
	output wire                  timer_output_pin_o,
	output wire                  irq_a_o,
	output wire                  irq_p_o
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	reg  [2:0] sub_s_q;
	reg  [2:0] ext_s_q;
	reg  [2:0] cap_s_q;
	reg  [2:0] per_s_q;
	reg  [3:0] filt_q;
	reg  [3:0] filt_d1_q;
	wire [3:0] rise;
	wire [3:0] fall;
	integer    i;

	function [2:0] sync3;
		input [2:0] s;
		input       pin;
		begin
			sync3 = {s[1:0], pin};
		end
	endfunction

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sub_s_q   <= 3'h0;
			ext_s_q   <= 3'h0;
			cap_s_q   <= 3'h0;
			per_s_q   <= 3'h0;
			filt_q    <= 4'h0;
			filt_d1_q <= 4'h0;
		end else begin
			sub_s_q <= sync3(sub_s_q, sub_clock_i);
			ext_s_q <= sync3(ext_s_q, ext_clock_pin_i);
			cap_s_q <= sync3(cap_s_q, capture_input_pin_i);
			per_s_q <= sync3(per_s_q, periodic_clock_capture_pin_i);
			// a change counts once stages two and three agree
			if (sub_s_q[1] == sub_s_q[2])
				filt_q[0] <= sub_s_q[2];
			if (ext_s_q[1] == ext_s_q[2])
				filt_q[1] <= ext_s_q[2];
			if (cap_s_q[1] == cap_s_q[2])
				filt_q[2] <= cap_s_q[2];
			if (per_s_q[1] == per_s_q[2])
				filt_q[3] <= per_s_q[2];
			filt_d1_q <= filt_q;
		end
	end

	assign rise = filt_q & ~filt_d1_q;
	assign fall = ~filt_q & filt_d1_q;

	// ****************************************
	// registers
	// ****************************************
	reg  [7:0]        ctrl0_q;
	reg  [7:0]        ctrl1_q;
	reg  [`CNT_W-1:0] cmpa_q;
	reg  [`CNT_W-1:0] cmpp_q;
	reg  [7:0]        buf_q;
	reg               flag_a_q;
	reg               flag_p_q;
	reg               cap_per_q;
	reg  [`CNT_W-1:0] cnt_q;
	reg               on_d1_q;
	reg               out_q;
	reg               sp_run_q;
	reg  [5:0]        pre_q;

	wire [2:0] cksel  = ctrl0_q[`C0_CKSEL_HI:`C0_CKSEL_LO];
	wire [1:0] mode   = ctrl1_q[`C1_MODE_HI:`C1_MODE_LO];
	wire [1:0] io     = ctrl1_q[`C1_IO_HI:`C1_IO_LO];
	wire       on     = ctrl0_q[`C0_ON];
	wire       pause  = ctrl0_q[`C0_PAUSE];
	wire       on_up  = on & ~on_d1_q;
	wire       single = (mode == `MODE_PWM) && (io == `PWM_SINGLE);

	// ****************************************
	// counter clock
	// ****************************************
	reg tick;

	always @* begin
		case (cksel)
		`CK_SYS_DIV4: tick = (pre_q[1:0] == 2'h3);
		`CK_SYS:      tick = 1'b1;
		`CK_HI_DIV16: tick = (pre_q[3:0] == 4'hf);
		`CK_HI_DIV64: tick = (pre_q == 6'h3f);
		`CK_SUB_A:    tick = rise[0];
		`CK_SUB_B:    tick = rise[0];
		`CK_EXT_RISE: tick = rise[1] & ~single;
		`CK_EXT_FALL: tick = fall[1] & ~single;
		default:      tick = 1'b0;
		endcase
	end

	// ****************************************
	// compare, capture and trigger events
	// ****************************************
	wire run     = on & ~pause & (~single | sp_run_q);
	wire step    = run & tick;
	wire match_a = step && (cnt_q == cmpa_q);
	wire match_p = step && (cnt_q == cmpp_q);
	wire dpx     = ctrl1_q[`C1_DPX];
	wire per_m   = dpx ? match_a : match_p;
	wire duty_m  = dpx ? match_p : match_a;
	wire clr_m   = (mode == `MODE_PWM) ? per_m :
	               (ctrl1_q[`C1_CCLR] ? match_a : match_p);

	// capture pin or periodic pin as capture source
	wire cap_r = cap_per_q ? rise[3] : rise[2];
	wire cap_f = cap_per_q ? fall[3] : fall[2];
	reg  cap_ev;

	always @* begin
		case (io)
		`IO_RISE: cap_ev = cap_r;
		`IO_FALL: cap_ev = cap_f;
		`IO_BOTH: cap_ev = cap_r | cap_f;
		default:  cap_ev = 1'b0;
		endcase
	end

	wire capture = on && (mode == `MODE_CAPTURE) && cap_ev;
	// single pulse trigger from the clock pin or the periodic pin
	wire trig = single & on & ~sp_run_q &
	            (cap_per_q ? rise[3] : rise[1]);

	// ****************************************
	// counter
	// ****************************************
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q    <= {`CNT_W{1'b0}};
			on_d1_q  <= 1'b0;
			pre_q    <= 6'h00;
			sp_run_q <= 1'b0;
		end else begin
			on_d1_q <= on;
			pre_q   <= pre_q + 6'h01;
			if (on_up || trig)
				cnt_q <= {`CNT_W{1'b0}};
			else if (step) begin
				if (clr_m)
					cnt_q <= {`CNT_W{1'b0}};
				else
					cnt_q <= cnt_q + {{(`CNT_W-1){1'b0}}, 1'b1};
			end
			if (!single || !on)
				sp_run_q <= 1'b0;
			else if (trig)
				sp_run_q <= 1'b1;
			else if (match_a)
				sp_run_q <= 1'b0;
		end
	end

	// ****************************************
	// output pin
	// ****************************************
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			out_q <= 1'b0;
		end else if (on_up || !on) begin
			out_q <= ctrl1_q[`C1_OC];
		end else begin
			case (mode)
			`MODE_CMP_OUT: begin
				if (match_a || match_p) begin
					case (io)
					`OUT_LOW:    out_q <= 1'b0;
					`OUT_HIGH:   out_q <= 1'b1;
					`OUT_TOGGLE: out_q <= ~out_q;
					default:     out_q <= out_q;
					endcase
				end
			end
			`MODE_PWM: begin
				if (single) begin
					if (trig)
						out_q <= 1'b1;
					else if (match_a)
						out_q <= 1'b0;
				end else if (per_m)
					out_q <= 1'b1;
				else if (duty_m)
					out_q <= 1'b0;
			end
			default: out_q <= out_q;
			endcase
		end
	end

	// same pin for compare output and PWM
	assign timer_output_pin_o = out_q ^ ctrl1_q[`C1_POL];

	// ****************************************
	// register bus
	// ****************************************
	wire wr_st = wr_i && (addr_i == `TM_STATUS);

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl0_q   <= `CTRL_RST;
			ctrl1_q   <= `CTRL_RST;
			cmpa_q    <= `CMP_RST;
			cmpp_q    <= `CMP_RST;
			buf_q     <= 8'h00;
			cap_per_q <= 1'b0;
			rdata_o   <= 8'h00;
		end else begin
			rdata_o <= 8'h00;
			if (wr_i) begin
				case (addr_i)
				`TM_CTRL0:   ctrl0_q <= wdata_i;
				`TM_CTRL1:   ctrl1_q <= wdata_i;
				`TM_CMPA_LO: buf_q   <= wdata_i;
				`TM_CMPP_LO: buf_q   <= wdata_i;
				`TM_CMPA_HI: cmpa_q  <= {wdata_i[1:0], buf_q};
				`TM_CMPP_HI: cmpp_q  <= {wdata_i[1:0], buf_q};
				`TM_AUX:     cap_per_q <= wdata_i[`AUX_CAP_PER];
				default:     cap_per_q <= cap_per_q;
				endcase
			end else if (rd_i) begin
				case (addr_i)
				`TM_CTRL0: rdata_o <= ctrl0_q;
				`TM_CTRL1: rdata_o <= ctrl1_q;
				`TM_CNT_HI: begin
					rdata_o <= {6'h00, cnt_q[9:8]};
					buf_q   <= cnt_q[7:0];
				end
				`TM_CMPA_HI: begin
					rdata_o <= {6'h00, cmpa_q[9:8]};
					buf_q   <= cmpa_q[7:0];
				end
				`TM_CMPP_HI: begin
					rdata_o <= {6'h00, cmpp_q[9:8]};
					buf_q   <= cmpp_q[7:0];
				end
				`TM_CNT_LO:  rdata_o <= buf_q;
				`TM_CMPA_LO: rdata_o <= buf_q;
				`TM_CMPP_LO: rdata_o <= buf_q;
				`TM_STATUS:  rdata_o <= {6'h00, flag_p_q, flag_a_q};
				`TM_AUX:     rdata_o <= {7'h00, cap_per_q};
				default:     rdata_o <= 8'h00;
				endcase
			end
			// capture loads comparator A with the count
			if (capture)
				cmpa_q <= cnt_q;
		end
	end

	// ****************************************
	// interrupt flags
	// ****************************************
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_a_q <= 1'b0;
			flag_p_q <= 1'b0;
		end else begin
			// set wins over a write-one clear
			if (match_a || capture)
				flag_a_q <= 1'b1;
			else if (wr_st && wdata_i[`ST_FLAG_A])
				flag_a_q <= 1'b0;
			if (match_p)
				flag_p_q <= 1'b1;
			else if (wr_st && wdata_i[`ST_FLAG_P])
				flag_p_q <= 1'b0;
		end
	end

	assign irq_a_o = flag_a_q;
	assign irq_p_o = flag_p_q;

endmodule // timer_module

// ===== sim/timer_module_properties.sv
module timer_module_properties (
	input wire logic       mclk_i,
	input wire logic       rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       timer_output_pin_o,
	input wire logic       irq_a_o,
	input wire logic       irq_p_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// shadow of the control registers
	// ****************************************
	logic [7:0] c0_q;
	logic [7:0] c1_q;
	logic       halt;
	logic       off;
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			c0_q <= 8'h00;
			c1_q <= 8'h00;
		end else if (wr_i && addr_i == 4'h0) begin
			c0_q <= wdata_i;
		end else if (wr_i && addr_i == 4'h1) begin
			c1_q <= wdata_i;
		end
	end
	assign halt = c0_q[7] | ~c0_q[3];
	assign off = ~c0_q[3];
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not idle");
	unmapped_zero_a: assert property ($past(rd_i) && $past(addr_i) > 4'h9 |-> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	hi_byte_a: assert property ($past(rd_i) && $past(addr_i) inside {4'h3, 4'h5, 4'h7}
		|-> rdata_o[7:2] == 6'h00)
		else $error("high byte upper bits set");
	status_mirror_a: assert property ($past(rd_i) && $past(addr_i) == 4'h8
		|-> rdata_o == {6'h00, $past(irq_p_o), $past(irq_a_o)})
		else $error("status read differs from flags");
	clock_sel_a: assert property ($past(rd_i) && $past(addr_i) == 4'h0
		|-> (rdata_o & 8'hf8) == ($past(c0_q) & 8'hf8))
		else $error("control0 readback wrong");
	flag_a_sticky_a: assert property (irq_a_o && !(wr_i && addr_i == 4'h8 && wdata_i[0])
		|=> irq_a_o)
		else $error("flag A dropped");
	flag_p_sticky_a: assert property (irq_p_o && !(wr_i && addr_i == 4'h8 && wdata_i[1])
		|=> irq_p_o)
		else $error("flag P dropped");
	frozen_flags_a: assert property (halt && $past(halt) && c1_q[7] == c1_q[6]
		|-> !$rose(irq_a_o) && !$rose(irq_p_o))
		else $error("flag rose while counter held");
	off_pin_a: assert property (off && $past(off) && $stable(c1_q)
		|-> timer_output_pin_o == (c1_q[3] ^ c1_q[2]))
		else $error("pin not at initial level");
	cover property ($rose(irq_a_o));
	cover property ($fell(irq_a_o));
	cover property ($rose(timer_output_pin_o));
endmodule // timer_module_properties

bind timer_module timer_module_properties i_timer_module_properties (.mclk_i, .rst_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .timer_output_pin_o, .irq_a_o, .irq_p_o);

// ===== sim/pin_model.sv
module pin_model (
	input wire logic mclk_i,
	output logic     ext_clock_pin_o,
	output logic     capture_input_pin_o,
	output logic     sub_clock_o,
	output logic     periodic_pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// external pins, wired straight to the timer
	// ****************************************
	initial begin
		ext_clock_pin_o = 1'b0;
		capture_input_pin_o = 1'b0;
		sub_clock_o = 1'b0;
		periodic_pin_o = 1'b0;
	end
	// one rising and one falling edge on the capture pin or the periodic pin
	task automatic cap_pulse(input bit per);
		repeat (6) @(posedge mclk_i);
		if (per)
			periodic_pin_o <= 1'b1;
		else
			capture_input_pin_o <= 1'b1;
		repeat (6) @(posedge mclk_i);
		periodic_pin_o <= 1'b0;
		capture_input_pin_o <= 1'b0;
		repeat (8) @(posedge mclk_i);
	endtask
	always begin
		repeat (5) @(posedge mclk_i);
		sub_clock_o <= ~sub_clock_o;
	end
	// levels last 6 cycles so the pin filter sees every edge
	task automatic pulses(input int n);
		repeat (n) begin
			repeat (6) @(posedge mclk_i);
			ext_clock_pin_o <= 1'b1;
			repeat (6) @(posedge mclk_i);
			ext_clock_pin_o <= 1'b0;
		end
		repeat (8) @(posedge mclk_i);
	endtask
endmodule // pin_model

// ===== sim/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic       mclk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i = 1'b0;
	logic       rd_i = 1'b0;
	logic [7:0] rdata_o;
	logic       sub_clock_i, ext_clock_pin_i, capture_input_pin_i, periodic_pin;
	logic       timer_output_pin_o, irq_a_o, irq_p_o;
	logic [7:0] exp_q[$];
	logic       rd_seen = 1'b0;
	logic [9:0] v;
	logic [7:0] b;
	int         n_errors = 0;
	int         n_tests = 0;
	`define CHECK(got, exp) begin \
		n_tests++; \
		if ((got) !== (exp)) begin \
			n_errors++; \
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp); \
		end \
	end
	initial forever #20 mclk_i = ~mclk_i;
	timer_module i_timer_module (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.sub_clock_i, .ext_clock_pin_i, .capture_input_pin_i,
		.periodic_clock_capture_pin_i(periodic_pin), .timer_output_pin_o, .irq_a_o, .irq_p_o);
	pin_model i_pin_model (.mclk_i, .ext_clock_pin_o(ext_clock_pin_i),
		.capture_input_pin_o(capture_input_pin_i), .sub_clock_o(sub_clock_i),
		.periodic_pin_o(periodic_pin));
	// ****************************************
	// register bus tasks and read scoreboard
	// ****************************************
	task wr(input logic [3:0] a, input logic [7:0] d);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		rd_i <= 1'b1;
		addr_i <= a;
		exp_q.push_back(e);
		@(posedge mclk_i);
		rd_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task w10(input logic [3:0] a, input logic [9:0] d);
		wr(a, d[7:0]);
		wr(a + 4'h1, {6'h00, d[9:8]});
	endtask
	task r10(input logic [3:0] a, input logic [9:0] d);
		rd(a + 4'h1, {6'h00, d[9:8]});
		rd(a, d[7:0]);
	endtask
	always @(posedge mclk_i) begin
		if (rd_seen)
			`CHECK(rdata_o, exp_q.pop_front())
		rd_seen <= rd_i;
	end
	task report_and_stop;
		$display("checks %0d, errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// tests need about 400 cycles
	initial begin
		repeat (20000) @(posedge mclk_i);
		n_errors++;
		report_and_stop;
	end
	initial begin
		void'($urandom(32'hadafa8de));
		repeat (4) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		for (int a = 0; a < 16; a++)
			rd(a[3:0], 8'h00);
		$display("reset values done");
		v = 10'($urandom);
		b = 8'($urandom);
		w10(4'h4, v);
		w10(4'h6, 10'h3ff);
		r10(4'h4, v);
		r10(4'h6, 10'h3ff);
		wr(4'h1, b);
		rd(4'h1, b);
		$display("buffered access done");
		wr(4'h1, 8'hc0);
		wr(4'h0, 8'h68);
		i_pin_model.pulses(5);
		r10(4'h2, 10'd5);
		wr(4'h0, 8'h78);
		rd(4'h0, 8'h78);
		i_pin_model.pulses(3);
		r10(4'h2, 10'd8);
		wr(4'h0, 8'hf8);
		i_pin_model.pulses(2);
		r10(4'h2, 10'd8);
		wr(4'h0, 8'h78);
		i_pin_model.pulses(1);
		r10(4'h2, 10'd9);
		wr(4'h0, 8'h70);
		i_pin_model.pulses(1);
		r10(4'h2, 10'd9);
		wr(4'h0, 8'h68);
		r10(4'h2, 10'd0);
		$display("external counting done");
		wr(4'h8, 8'h03);
		wr(4'h1, 8'h30);
		w10(4'h4, 10'd2);
		wr(4'h0, 8'h00);
		wr(4'h0, 8'h68);
		`CHECK(timer_output_pin_o, 1'b0)
		i_pin_model.pulses(3);
		`CHECK(irq_a_o, 1'b1)
		`CHECK(timer_output_pin_o, 1'b1)
		rd(4'h8, 8'h01);
		wr(4'h8, 8'h01);
		rd(4'h8, 8'h00);
		$display("compare match done");
		wr(4'h1, 8'h40);
		i_pin_model.cap_pulse(1'b0);
		r10(4'h4, 10'd3);
		rd(4'h8, 8'h01);
		wr(4'h9, 8'h01);
		wr(4'h8, 8'h01);
		i_pin_model.cap_pulse(1'b1);
		rd(4'h8, 8'h01);
		$display("capture done");
		report_and_stop;
	end
endmodule // testbench
